// File: core/port_function_select_regs.sv
// Port function select registers behind an AXI4-Lite slave
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module port_function_select_regs (
   input  wire logic                                        sys_clk,
   input  wire logic                                        rst_n,
   // Mode pins
   input  wire logic                                        rom_disabled_mode,
   input  wire logic                                        ext_extended_mode,
   // AXI4-Lite slave
   input  wire logic [port_function_select_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                                        s_axi_awvalid,
   output logic                                             s_axi_awready,
   input  wire logic [31:0]                                 s_axi_wdata,
   input  wire logic [3:0]                                  s_axi_wstrb,
   input  wire logic                                        s_axi_wvalid,
   output logic                                             s_axi_wready,
   output logic [1:0]                                       s_axi_bresp,
   output logic                                             s_axi_bvalid,
   input  wire logic                                        s_axi_bready,
   input  wire logic [port_function_select_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                                        s_axi_arvalid,
   output logic                                             s_axi_arready,
   output logic [31:0]                                      s_axi_rdata,
   output logic [1:0]                                       s_axi_rresp,
   output logic                                             s_axi_rvalid,
   input  wire logic                                        s_axi_rready,
   // Pin function controls
   output logic [7:0]                                       addr_line_enable,
   output logic                                             low_half_write_strobe_enable,
   output logic                                             low_half_write_strobe_pin_on,
   output logic                                             timer_ext_clock_pin_select,
   output logic [1:0]                                       dma_ch3_pin_sel,
   output logic [1:0]                                       dma_ch2_pin_sel,
   output logic [1:0]                                       dma_ch1_pin_sel,
   output logic [1:0]                                       dma_ch0_pin_sel
);
   import port_function_select_pkg::*;

   //---------------------------------------------------------------------------
   // Mode pin synchronisers
   //---------------------------------------------------------------------------
   logic [1:0] mode_s1;
   logic [1:0] mode_s2;
   logic [1:0] mode_s3;
   logic [1:0] mode_filt;
   logic [1:0] next_mode_filt;

   // A change counts once the second and third stages agree
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         next_mode_filt[i] = (mode_s2[i] == mode_s3[i]) ? mode_s3[i] : mode_filt[i];
      end
   end

   // Free running so the strap is settled while reset is held
   always_ff @(posedge sys_clk) begin
      mode_s1   <= {ext_extended_mode, rom_disabled_mode};
      mode_s2   <= mode_s1;
      mode_s3   <= mode_s2;
      mode_filt <= next_mode_filt;
   end

   //---------------------------------------------------------------------------
   // Bus write channel
   //---------------------------------------------------------------------------
   logic              aw_held;
   logic              w_held;
   logic [ADDR_W-1:0] wr_addr;
   logic [7:0]        wr_data;
   logic              wr_lane;
   logic              next_aw_held;
   logic              next_w_held;
   logic [ADDR_W-1:0] next_wr_addr;
   logic [7:0]        next_wr_data;
   logic              next_wr_lane;
   logic              next_bvalid;
   logic [1:0]        next_bresp;
   logic              wr_fire;
   logic              wr_hit;

   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_hit  = (wr_addr == ADDR_OUTPUT_ENABLE_OFS) || (wr_addr == STROBE_TIMER_SEL_OFS)
                    || (wr_addr == DMA_PIN_SELECT_OFS);

   // Address and data are taken in either order, answer follows both
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      next_wr_lane = wr_lane;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_wr_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held  = 1'b1;
         next_wr_data = s_axi_wdata[7:0];
         next_wr_lane = s_axi_wstrb[0];
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
   end

   // Write channel state
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         wr_addr       <= '0;
         wr_data       <= 8'h00;
         wr_lane       <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         aw_held       <= next_aw_held;
         w_held        <= next_w_held;
         wr_addr       <= next_wr_addr;
         wr_data       <= next_wr_data;
         wr_lane       <= next_wr_lane;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_awready <= !next_aw_held && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !next_w_held && !(s_axi_wvalid && s_axi_wready);
      end
   end

   //---------------------------------------------------------------------------
   // Configuration registers
   //---------------------------------------------------------------------------
   logic       strobe_en;
   logic       timer_sel;
   logic [7:0] strobe_reg_view;
   logic [7:0] dma_reg_view;
   logic [7:0] next_addr_line_enable;
   logic       next_strobe_en;
   logic       next_timer_sel;
   logic [7:0] next_dma_reg;
   logic       wr_lane_ok;

   assign wr_lane_ok      = wr_fire && wr_lane;
   // Fixed ones at bits 7 and 5, zeros at bit 4 and bits 2 to 0
   assign strobe_reg_view = STROBE_FIXED_ONES // [RULE5] [RULE6] [RULE8]
                            | {1'b0, strobe_en, 2'b00, timer_sel, 3'b000};
   assign dma_reg_view    = {dma_ch3_pin_sel, dma_ch2_pin_sel, dma_ch1_pin_sel, dma_ch0_pin_sel};

   // Register updates from the bus
   always_comb begin
      next_addr_line_enable = addr_line_enable;
      next_strobe_en        = strobe_en;
      next_timer_sel        = timer_sel;
      next_dma_reg          = dma_reg_view;
      if (wr_lane_ok && (wr_addr == ADDR_OUTPUT_ENABLE_OFS)) begin
         next_addr_line_enable = wr_data; // [RULE1]
      end
      if (wr_lane_ok && (wr_addr == STROBE_TIMER_SEL_OFS)) begin
         next_strobe_en = wr_data[STROBE_ENABLE_BIT]; // [RULE4]
         next_timer_sel = wr_data[TIMER_CLK_SEL_BIT]; // [RULE7]
      end
      if (wr_lane_ok && (wr_addr == DMA_PIN_SELECT_OFS)) begin
         next_dma_reg = wr_data; // [RULE9]
      end
   end

   // Register storage, the lower address enable reset values follow the ROM mode strap
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         addr_line_enable <= ADDR_HI_RESET | {3'b000, {5{mode_filt[0]}}}; // [RULE2] [RULE3]
         strobe_en        <= STROBE_ENABLE_RESET;
         timer_sel        <= TIMER_CLK_SEL_RESET;
         {dma_ch3_pin_sel, dma_ch2_pin_sel, dma_ch1_pin_sel, dma_ch0_pin_sel}
            <= DMA_PIN_RESET; // [RULE14]
         low_half_write_strobe_enable <= STROBE_ENABLE_RESET;
         low_half_write_strobe_pin_on <= 1'b0;
         timer_ext_clock_pin_select   <= TIMER_CLK_SEL_RESET;
      end else begin
         addr_line_enable <= next_addr_line_enable;
         strobe_en        <= next_strobe_en;
         timer_sel        <= next_timer_sel;
         {dma_ch3_pin_sel, dma_ch2_pin_sel, dma_ch1_pin_sel, dma_ch0_pin_sel}
            <= next_dma_reg; // [RULE12] [RULE13]
         low_half_write_strobe_enable <= next_strobe_en;
         low_half_write_strobe_pin_on <= next_strobe_en && mode_filt[1]; // [RULE4]
         timer_ext_clock_pin_select   <= next_timer_sel; // [RULE7]
      end
   end

   //---------------------------------------------------------------------------
   // Bus read channel
   //---------------------------------------------------------------------------
   logic        next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;

   // One read at a time, answered the cycle after the address is taken
   always_comb begin
      next_rvalid = s_axi_rvalid;
      next_rdata  = s_axi_rdata;
      next_rresp  = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         case (s_axi_araddr)
            ADDR_OUTPUT_ENABLE_OFS: next_rdata = {24'h00_0000, addr_line_enable};
            STROBE_TIMER_SEL_OFS:   next_rdata = {24'h00_0000, strobe_reg_view};
            DMA_PIN_SELECT_OFS:     next_rdata = {24'h00_0000, dma_reg_view}; // [RULE14]
            default: begin
               next_rdata = 32'h0000_0000;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   // Read channel state
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
         s_axi_arready <= !next_rvalid;
      end
   end

   //---------------------------------------------------------------------------
   // Assertions
   //---------------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_addr_hi_reset: assert property ($past(!rst_n) |-> addr_line_enable[7:5] == 3'b000) // [RULE2]
      else $error("upper address enables not cleared by reset");
   a_addr_lo_reset: assert property ($past(!rst_n) |-> // [RULE3]
      addr_line_enable[4:0] == {5{$past(mode_filt[0])}})
      else $error("lower address enables do not follow ROM mode");
   a_addr_write: assert property (wr_lane_ok && wr_addr == ADDR_OUTPUT_ENABLE_OFS // [RULE1]
      |=> addr_line_enable == $past(wr_data))
      else $error("address enable write lost");
   a_strobe_pin_mode: assert property (##1 low_half_write_strobe_pin_on == // [RULE4]
      (low_half_write_strobe_enable && $past(mode_filt[1])))
      else $error("strobe pin not gated by extended mode");
   a_strobe_write: assert property (wr_lane_ok && wr_addr == STROBE_TIMER_SEL_OFS // [RULE4]
      |=> low_half_write_strobe_enable == $past(wr_data[STROBE_ENABLE_BIT]))
      else $error("strobe enable write lost");
   a_fixed_bits: assert property (s_axi_arvalid && s_axi_arready // [RULE5] [RULE6] [RULE8]
      && s_axi_araddr == STROBE_TIMER_SEL_OFS |=> s_axi_rdata[7] && s_axi_rdata[5]
      && !s_axi_rdata[4] && s_axi_rdata[2:0] == 3'b000)
      else $error("fixed bits of strobe register wrong");
   a_timer_write: assert property (wr_lane_ok && wr_addr == STROBE_TIMER_SEL_OFS // [RULE7]
      |=> timer_ext_clock_pin_select == $past(wr_data[TIMER_CLK_SEL_BIT]))
      else $error("timer clock select write lost");
   a_dma_write: assert property (wr_lane_ok && wr_addr == DMA_PIN_SELECT_OFS // [RULE9]
      |=> dma_ch3_pin_sel == $past(wr_data[7:6]) && dma_ch2_pin_sel == $past(wr_data[5:4])
      && dma_ch1_pin_sel == $past(wr_data[3:2]) && dma_ch0_pin_sel == $past(wr_data[1:0]))
      else $error("DMA pin field write misplaced");
   a_dma_reset: assert property ($past(!rst_n) |-> dma_reg_view == DMA_PIN_RESET) // [RULE14]
      else $error("DMA pin fields not cleared by reset");
   a_read_back: assert property (s_axi_arvalid && s_axi_arready // [RULE14]
      && s_axi_araddr == DMA_PIN_SELECT_OFS
      |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(dma_reg_view))
      else $error("DMA register read back wrong");
   a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr != ADDR_OUTPUT_ENABLE_OFS && s_axi_araddr != STROBE_TIMER_SEL_OFS
      && s_axi_araddr != DMA_PIN_SELECT_OFS |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR)
      else $error("unmapped read not refused");
   a_write_refused: assert property (wr_fire && !wr_hit
      |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR && $stable(addr_line_enable))
      else $error("unmapped write not refused");
   a_lane_off: assert property (wr_fire && !wr_lane
      |=> $stable(addr_line_enable) && $stable(dma_reg_view) && $stable(strobe_reg_view))
      else $error("write with low lane off changed a register");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");

   // Main scenarios that the bench is expected to reach
   c_write_dma:   cover property (wr_lane_ok && wr_addr == DMA_PIN_SELECT_OFS);
   c_read_strobe: cover property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr == STROBE_TIMER_SEL_OFS);
   c_strobe_pin:  cover property (low_half_write_strobe_pin_on);
   c_unmapped:    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   c_bready_late: cover property (s_axi_bvalid && !s_axi_bready);

endmodule // port_function_select_regs

// File: core/port_function_select_pkg.sv
// Constants, offsets and reset values for the port function select registers
//------------------------------------------------------------------------------
// Operation
// RULE1 - Each address register bit enables one address line, bit 7 is line 23
// RULE2 - Address lines 23, 22 and 21 enables clear after reset in any mode
// RULE3 - Lines 20 to 16 reset enabled when ROM disabled, else disabled
// RULE4 - Strobe enable bit 6 resets 1, drives strobe pin only in extended mode
// RULE5 - Second register bits 7 and 5 reset and read as 1; write 1
// RULE6 - Second register bit 4 reads 0, read-only, writes ignored
// RULE7 - Bit 3 resets 0, picks first or alternate timer clock pin group
// RULE8 - Second register bits 2 to 0 reset and read 0; write 0
// RULE9 - Third register holds four 2-bit DMA channel pin fields, channel 3 top
// RULE10 - Software writes only 01 to the channel 3 field
// RULE11 - Software writes only 01 to the channel 2 field
// RULE12 - Channel 1 field: 00 first group, 01 second group; no 10 or 11
// RULE13 - Channel 0 field: 00 first group, 01 second group; no 10 or 11
// RULE14 - Writable bits read back; DMA fields reset to zero
//------------------------------------------------------------------------------
package port_function_select_pkg;

   //---------------------------------------------------------------------------
   // Bus geometry and register offsets
   //---------------------------------------------------------------------------
   localparam int unsigned ADDR_W = 4;
   localparam logic [ADDR_W-1:0] ADDR_OUTPUT_ENABLE_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] STROBE_TIMER_SEL_OFS   = 4'h4;
   localparam logic [ADDR_W-1:0] DMA_PIN_SELECT_OFS     = 4'h8;

   //---------------------------------------------------------------------------
   // Field positions and reset values
   //---------------------------------------------------------------------------
   localparam logic [7:0] ADDR_HI_RESET      = 8'h00;
   localparam int unsigned STROBE_ENABLE_BIT = 6;
   localparam int unsigned TIMER_CLK_SEL_BIT = 3;
   localparam logic STROBE_ENABLE_RESET      = 1'b1;
   localparam logic TIMER_CLK_SEL_RESET      = 1'b0;
   localparam logic [7:0] STROBE_FIXED_ONES  = 8'hA0;
   localparam logic [7:0] DMA_PIN_RESET      = 8'h00;
   localparam logic [1:0] DMA_SEL_FIRST      = 2'h0;
   localparam logic [1:0] DMA_SEL_SECOND     = 2'h1;

   //---------------------------------------------------------------------------
   // Bus answer codes
   //---------------------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: testbench/port_function_select_regs_tb.sv
// Self-checking testbench for the port function select registers
`timescale 1ns/1ps
module port_function_select_regs_tb;
   import port_function_select_pkg::*;
   //---------------------------------------------------------------------------
   // Stimulus and observed signals
   //---------------------------------------------------------------------------
   logic              sys_clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              rom_disabled_mode = 1'b1;
   logic              ext_extended_mode = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0]       wdata = 32'h0000_0000;
   logic [3:0]        wstrb = 4'h0;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [1:0]        bresp, rresp;
   logic [31:0]       rdata;
   logic [7:0]        addr_line_enable;
   logic              strobe_en, strobe_pin_on, timer_sel;
   logic [1:0]        ch3, ch2, ch1, ch0;
   int                n_mismatch = 0;
   int                tests_run = 0;

   // Clock at 100 MHz
   always #5 sys_clk = ~sys_clk;

   port_function_select_regs dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .rom_disabled_mode(rom_disabled_mode),
      .ext_extended_mode(ext_extended_mode), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .addr_line_enable(addr_line_enable), .low_half_write_strobe_enable(strobe_en),
      .low_half_write_strobe_pin_on(strobe_pin_on), .timer_ext_clock_pin_select(timer_sel),
      .dma_ch3_pin_sel(ch3), .dma_ch2_pin_sel(ch2), .dma_ch1_pin_sel(ch1),
      .dma_ch0_pin_sel(ch0));

   //---------------------------------------------------------------------------
   // Shared tasks
   //---------------------------------------------------------------------------
   // Compare and count
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One AXI write; address and data released independently as each is taken
   // Response ready may be held back for a few cycles to stall the answer
   task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s,
                         input logic [1:0] exp_resp, input int bwait = 0);
      logic done;
      int   n;
      done = 1'b0;
      n = 0;
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= {24'h00_0000, d};
      wstrb   <= s;
      wvalid  <= 1'b1;
      bready  <= (bwait == 0);
      while (!done) begin
         @(posedge sys_clk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1 && bready === 1'b1) begin
            done = 1'b1;
            bready <= 1'b0;
            chk("bresp", {30'h0, exp_resp}, {30'h0, bresp});
         end else if (n >= bwait) begin
            bready <= 1'b1;
         end
      end
      @(posedge sys_clk);
   endtask

   // One AXI read, compared against the expected word and answer code
   task automatic axi_rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
      logic done;
      done = 1'b0;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!done) begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            done = 1'b1;
            rready <= 1'b0;
            chk("rdata", exp, rdata);
            chk("rresp", {30'h0, exp_resp}, {30'h0, rresp});
         end
      end
      @(posedge sys_clk);
   endtask

   //---------------------------------------------------------------------------
   // Scenarios
   //---------------------------------------------------------------------------
   // Reset in either ROM mode and check every reset value except the strobe pin at ports and over the bus
   task automatic t_reset(input logic rom, input int hold);
      rst_n <= 1'b0;
      rom_disabled_mode <= rom;
      ext_extended_mode <= 1'b0;
      repeat (hold) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("addr_line_enable", {27'h0, {5{rom}}}, {24'h0, addr_line_enable});
      chk("strobe_en", 32'h0000_0001, {31'h0, strobe_en});
      chk("timer_sel", 32'h0000_0000, {31'h0, timer_sel});
      chk("dma_fields", 32'h0000_0000, {24'h0, ch3, ch2, ch1, ch0});
      axi_rd(ADDR_OUTPUT_ENABLE_OFS, {24'h0, 3'b000, {5{rom}}}, RESP_OKAY);
      axi_rd(STROBE_TIMER_SEL_OFS, 32'h0000_00E0, RESP_OKAY);
      axi_rd(DMA_PIN_SELECT_OFS, 32'h0000_0000, RESP_OKAY);
      $display("test reset rom=%0d done", rom);
   endtask

   // Each address bit drives its own line, bit 7 is the highest line
   task automatic t_addr();
      axi_wr(ADDR_OUTPUT_ENABLE_OFS, 8'h81, 4'h1, RESP_OKAY);
      chk("addr_line_enable", 32'h0000_0081, {24'h0, addr_line_enable});
      axi_wr(ADDR_OUTPUT_ENABLE_OFS, 8'h5A, 4'h1, RESP_OKAY);
      chk("addr_line_enable", 32'h0000_005A, {24'h0, addr_line_enable});
      axi_rd(ADDR_OUTPUT_ENABLE_OFS, 32'h0000_005A, RESP_OKAY);
      $display("test address enables done");
   endtask

   // Strobe enable, fixed bits and timer clock select in the second register
   task automatic t_strobe();
      ext_extended_mode <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk("strobe_pin_on", 32'h0000_0001, {31'h0, strobe_pin_on});
      axi_wr(STROBE_TIMER_SEL_OFS, 8'hB8, 4'h1, RESP_OKAY);
      chk("strobe_en", 32'h0000_0000, {31'h0, strobe_en});
      chk("timer_sel", 32'h0000_0001, {31'h0, timer_sel});
      repeat (2) @(posedge sys_clk);
      chk("strobe_pin_on", 32'h0000_0000, {31'h0, strobe_pin_on});
      axi_rd(STROBE_TIMER_SEL_OFS, 32'h0000_00A8, RESP_OKAY);
      axi_wr(STROBE_TIMER_SEL_OFS, 8'hE0, 4'h1, RESP_OKAY);
      ext_extended_mode <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk("strobe_en", 32'h0000_0001, {31'h0, strobe_en});
      chk("strobe_pin_on", 32'h0000_0000, {31'h0, strobe_pin_on});
      chk("timer_sel", 32'h0000_0000, {31'h0, timer_sel});
      $display("test strobe and timer select done");
   endtask

   // Every legal code of the DMA fields, channel 3 in the top bits
   task automatic t_dma();
      logic [7:0] v [3];
      v = '{8'h54, 8'h51, 8'h55};
      for (int i = 0; i < 3; i++) begin
         axi_wr(DMA_PIN_SELECT_OFS, v[i], 4'h1, RESP_OKAY);
         chk("dma_fields", {24'h0, v[i]}, {24'h0, ch3, ch2, ch1, ch0});
         axi_rd(DMA_PIN_SELECT_OFS, {24'h0, v[i]}, RESP_OKAY);
      end
      $display("test dma pin select done");
   endtask

   // Unmapped address, a write with the low byte strobe off and a stalled answer
   task automatic t_refused();
      axi_wr(4'hC, 8'hFF, 4'h1, RESP_SLVERR);
      axi_rd(4'hC, 32'h0000_0000, RESP_SLVERR);
      axi_wr(ADDR_OUTPUT_ENABLE_OFS, 8'h00, 4'h0, RESP_OKAY);
      chk("addr_line_enable", 32'h0000_005A, {24'h0, addr_line_enable});
      axi_rd(DMA_PIN_SELECT_OFS, 32'h0000_0055, RESP_OKAY);
      axi_wr(ADDR_OUTPUT_ENABLE_OFS, 8'h3C, 4'h1, RESP_OKAY, 4);
      chk("addr_line_enable", 32'h0000_003C, {24'h0, addr_line_enable});
      $display("test refused accesses done");
   endtask

   //---------------------------------------------------------------------------
   // Verdict, watchdog and main sequence
   //---------------------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Cuts a hang short well beyond the expected run length
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_mismatch++;
      complete_run();
   end

   initial begin
      t_reset(1'b1, 5);
      t_addr();
      t_strobe();
      t_dma();
      t_refused();
      t_reset(1'b0, 8);
      complete_run();
   end
endmodule // port_function_select_regs_tb
